// [ocft_pkg.sv]
// constants for the overcurrent / overtemperature fault response block
// assumes a 100 MHz mclk and a decoded command port ahead of it
package ocft_pkg;
	// command codes of the threshold and response words
	localparam logic [7:0] CMD_OC_FAULT_THR = 8'h46;
	localparam logic [7:0] CMD_OC_REACTION = 8'h47;
	localparam logic [7:0] CMD_OC_WARN_THR = 8'h4a;
	localparam logic [7:0] CMD_OT_FAULT_THR = 8'h4f;
	// reaction word fields
	localparam int DELAY_LSB = 0;
	localparam int DELAY_W = 3;
	localparam int RETRY_LSB = 3;
	localparam int RETRY_W = 3;
	localparam int RESP_LSB = 6;
	localparam int RESP_W = 2;
	localparam logic [1:0] RESP_IGNORE = 2'h0;
	localparam logic [1:0] RESP_DISABLE = 2'h3;
	localparam logic [2:0] RETRY_NONE = 3'h0;
	localparam logic [2:0] RETRY_FOREVER = 3'h7;
	// reset values (plain defaults)
	localparam logic [7:0] OC_REACTION_RST = 8'hc0;
	localparam logic [15:0] OC_FAULT_THR_RST = 16'h00f0;
	localparam logic [15:0] OC_WARN_THR_RST = 16'h00c8;
	localparam logic [15:0] OT_FAULT_THR_RST = 16'h007d;
	// retry interval unit
	localparam int CLK_MHZ = 100;
	localparam int UNIT_MS = 200;
	localparam int UNIT_CYCLES = UNIT_MS * 1000 * CLK_MHZ;
	// response sequencer states
	typedef enum logic [2:0] {
		ST_OFF,
		ST_RUN,
		ST_WAIT,
		ST_RESTART,
		ST_LATCHED
	} resp_state_t;
endpackage

// [ocft_fault_response.sv]
// overcurrent / overtemperature fault detection and overcurrent response sequencer
// assumes measured values arrive on mclk in the same linear format as the thresholds,
// and that an upstream command engine presents decoded register writes and reads
//
// Contract
// - reaction bits 2:0 set the interval between restart attempts in 200 ms units.
// - an overcurrent fault always sets its status flag and notifies the host.
// - response code 00 keeps running and limits current at the fault threshold.
// - response code 11 disables the output on a fault and follows the retry field.
// - reaction bits 5:3 give the number of restart attempts after a shutdown.
// - retry count 000 means no restart and output off until the fault is cleared.
// - retry counts 1 to 6 allow that many restarts, then output off until cleared.
// - retry count 111 retries forever until commanded off, bias loss or another fault.
// - the warning flag rises only when current strictly exceeds the warning threshold.
`timescale 1ns/1ps
module ocft_fault_response
	import ocft_pkg::*;
#(
	parameter int UNIT_CLKS = ocft_pkg::UNIT_CYCLES
) (
	// clock and reset
	input wire logic mclk,
	input wire logic nrst,
	// command port
	input wire logic [7:0] cmd_code,
	input wire logic cmd_wr,
	input wire logic [15:0] cmd_wdata,
	output logic [15:0] cmd_rdata,
	output logic cmd_hit,
	// measurements and power stage
	input wire logic [15:0] iout_meas,
	input wire logic [15:0] temp_meas,
	input wire logic restart_ok,
	input wire logic other_fault,
	input wire logic fault_clear,
	// pins
	input wire logic ctrl_pin,
	input wire logic bias_good,
	// outputs
	output logic out_enable,
	output logic current_limit,
	output logic [15:0] current_limit_value,
	output logic oc_fault_flag,
	output logic oc_warn_flag,
	output logic ot_fault_flag,
	output logic host_alert,
	output logic [2:0] retries_left
);
	import ocft_pkg::*;

	// the interval timer needs at least one cycle per unit
	initial begin
		if (UNIT_CLKS < 1)
			$error("UNIT_CLKS must be at least one");
	end

	// seven units, the longest interval, must fit the 32-bit timer
	initial begin
		if (longint'(UNIT_CLKS) * 64'd7 > 64'hffff_ffff)
			$error("UNIT_CLKS too large for the interval timer");
	end

	// the reaction word fields must tile its eight bits
	initial begin
		if (RESP_LSB + RESP_W != 8 || RETRY_LSB + RETRY_W != RESP_LSB || DELAY_LSB + DELAY_W != RETRY_LSB)
			$error("reaction word fields overlap");
	end

	// one-cycle step of the interval timer and of the attempt count
	localparam logic [31:0] TIMER_ONE = 32'h1;
	localparam logic [2:0] RETRY_ONE = 3'h1;

	logic [7:0] oc_reaction_r;
	logic [15:0] oc_fault_thr_r;
	logic [15:0] oc_warn_thr_r;
	logic [15:0] ot_fault_thr_r;
	logic [1:0] ctrl_sync_r;
	logic [1:0] bias_sync_r;
	resp_state_t state_r;
	resp_state_t state_nxt;
	logic [31:0] timer_r;
	logic [2:0] retries_r;
	logic oc_now;
	logic warn_now;
	logic ot_now;
	logic run_allowed;
	logic [1:0] resp_code;
	logic [2:0] retry_set;
	logic [2:0] delay_set;

	// strict greater-than compare shared by all trip points
	function automatic logic exceeds(input logic [15:0] meas, input logic [15:0] thr);
		exceeds = meas > thr;
	endfunction

	// restart interval in cycles, a zero field still waits one cycle
	function automatic logic [31:0] interval_cycles(input logic [2:0] units);
		if (units == 3'h0)
			interval_cycles = TIMER_ONE;
		else
			interval_cycles = 32'(units) * 32'(UNIT_CLKS);
	endfunction

	// write strobe decode, shared by every register
	function automatic logic wr_to(input logic wr, input logic [7:0] sel, input logic [7:0] code);
		wr_to = wr && sel == code;
	endfunction

	// reaction word fields
	assign resp_code = oc_reaction_r[RESP_LSB +: RESP_W];
	assign retry_set = oc_reaction_r[RETRY_LSB +: RETRY_W];
	assign delay_set = oc_reaction_r[DELAY_LSB +: DELAY_W];

	// overcurrent reaction word
	always_ff @(posedge mclk) begin
		if (!nrst)
			oc_reaction_r <= OC_REACTION_RST;
		else if (wr_to(cmd_wr, cmd_code, CMD_OC_REACTION))
			oc_reaction_r <= cmd_wdata[7:0];
	end

	// overcurrent fault threshold, shared by limiting and detection
	always_ff @(posedge mclk) begin
		if (!nrst)
			oc_fault_thr_r <= OC_FAULT_THR_RST;
		else if (wr_to(cmd_wr, cmd_code, CMD_OC_FAULT_THR))
			oc_fault_thr_r <= cmd_wdata;
	end

	// overcurrent warning threshold
	always_ff @(posedge mclk) begin
		if (!nrst)
			oc_warn_thr_r <= OC_WARN_THR_RST;
		else if (wr_to(cmd_wr, cmd_code, CMD_OC_WARN_THR))
			oc_warn_thr_r <= cmd_wdata;
	end

	// overtemperature fault threshold
	always_ff @(posedge mclk) begin
		if (!nrst)
			ot_fault_thr_r <= OT_FAULT_THR_RST;
		else if (wr_to(cmd_wr, cmd_code, CMD_OT_FAULT_THR))
			ot_fault_thr_r <= cmd_wdata;
	end

	// register reads, unknown codes answer zero with no hit
	always_comb begin
		cmd_rdata = 16'h0000;
		cmd_hit = 1'b1;
		unique case (cmd_code)
			CMD_OC_REACTION: cmd_rdata = {8'h00, oc_reaction_r};
			CMD_OC_FAULT_THR: cmd_rdata = oc_fault_thr_r;
			CMD_OC_WARN_THR: cmd_rdata = oc_warn_thr_r;
			CMD_OT_FAULT_THR: cmd_rdata = ot_fault_thr_r;
			default: cmd_hit = 1'b0;
		endcase
	end

	// two-stage synchroniser for the control pin
	always_ff @(posedge mclk) begin
		if (!nrst)
			ctrl_sync_r <= 2'h0;
		else
			ctrl_sync_r <= {ctrl_sync_r[0], ctrl_pin};
	end

	// two-stage synchroniser for the bias pin
	always_ff @(posedge mclk) begin
		if (!nrst)
			bias_sync_r <= 2'h0;
		else
			bias_sync_r <= {bias_sync_r[0], bias_good};
	end

	// trip comparisons
	assign oc_now = exceeds(iout_meas, oc_fault_thr_r);
	assign warn_now = exceeds(iout_meas, oc_warn_thr_r);
	assign ot_now = exceeds(temp_meas, ot_fault_thr_r);

	// running needs both pins and no other fault
	assign run_allowed = ctrl_sync_r[1] && bias_sync_r[1] && !other_fault;

	// sticky overcurrent fault flag, a new event wins over a clear
	always_ff @(posedge mclk) begin
		if (!nrst)
			oc_fault_flag <= 1'b0;
		else
			oc_fault_flag <= oc_now || (oc_fault_flag && !fault_clear);
	end

	// sticky overcurrent warning flag
	always_ff @(posedge mclk) begin
		if (!nrst)
			oc_warn_flag <= 1'b0;
		else
			oc_warn_flag <= warn_now || (oc_warn_flag && !fault_clear);
	end

	// sticky overtemperature fault flag
	always_ff @(posedge mclk) begin
		if (!nrst)
			ot_fault_flag <= 1'b0;
		else
			ot_fault_flag <= ot_now || (ot_fault_flag && !fault_clear);
	end

	// host notification follows any pending flag
	assign host_alert = oc_fault_flag || oc_warn_flag || ot_fault_flag;

	// response sequencer next state
	always_comb begin
		state_nxt = state_r;
		unique case (state_r)
			ST_OFF: begin
				if (run_allowed)
					state_nxt = ST_RUN;
			end
			ST_RUN: begin
				if (!run_allowed)
					state_nxt = ST_OFF;
				else if (oc_now && resp_code == RESP_DISABLE)
					state_nxt = (retry_set == RETRY_NONE) ? ST_LATCHED : ST_WAIT;
			end
			ST_WAIT: begin
				if (!run_allowed)
					state_nxt = ST_OFF;
				else if (fault_clear)
					state_nxt = ST_RUN;
				else if (timer_r <= TIMER_ONE)
					state_nxt = ST_RESTART;
			end
			ST_RESTART: begin
				if (!run_allowed)
					state_nxt = ST_OFF;
				else if (oc_now)
					state_nxt = (retries_r == 3'h0) ? ST_LATCHED : ST_WAIT;
				else if (restart_ok)
					state_nxt = ST_RUN;
			end
			ST_LATCHED: begin
				if (fault_clear)
					state_nxt = run_allowed ? ST_RUN : ST_OFF;
			end
			default: state_nxt = ST_OFF;
		endcase
	end

	// sequencer state
	always_ff @(posedge mclk) begin
		if (!nrst)
			state_r <= ST_OFF;
		else
			state_r <= state_nxt;
	end

	// restart interval timer, loaded on each entry to the wait state
	always_ff @(posedge mclk) begin
		if (!nrst)
			timer_r <= 32'h0;
		else if (state_nxt == ST_WAIT && state_r != ST_WAIT)
			timer_r <= interval_cycles(delay_set);
		else if (timer_r != 32'h0)
			timer_r <= timer_r - TIMER_ONE;
	end

	// remaining attempts, spent on each restart start
	always_ff @(posedge mclk) begin
		if (!nrst)
			retries_r <= 3'h0;
		else if (state_r == ST_RUN || fault_clear || state_r == ST_OFF)
			retries_r <= retry_set;
		else if (state_r == ST_WAIT && state_nxt == ST_RESTART && retry_set != RETRY_FOREVER)
			retries_r <= retries_r - RETRY_ONE;
		else if (retry_set == RETRY_FOREVER)
			retries_r <= RETRY_FOREVER;
	end

	// remaining attempts shown to the host side
	assign retries_left = retries_r;

	// output drive, on while running or attempting a restart
	always_ff @(posedge mclk) begin
		if (!nrst)
			out_enable <= 1'b0;
		else
			out_enable <= state_nxt == ST_RUN || state_nxt == ST_RESTART;
	end

	// constant-current limiting under the ignore response
	always_ff @(posedge mclk) begin
		if (!nrst)
			current_limit <= 1'b0;
		else
			current_limit <= state_nxt == ST_RUN && resp_code == RESP_IGNORE && oc_now;
	end

	// current held at the fault threshold while limiting
	always_ff @(posedge mclk) begin
		if (!nrst)
			current_limit_value <= 16'h0000;
		else
			current_limit_value <= oc_fault_thr_r;
	end
endmodule

// [ocft_host_model.sv]
// host side model: writes and reads registers over the command port
// assumes the block samples the port on rising mclk edges
`timescale 1ns/1ps
module ocft_host_model(
	// command port
	input wire logic mclk,
	output logic [7:0] cmd_code,
	output logic cmd_wr,
	output logic [15:0] cmd_wdata,
	input wire logic [15:0] cmd_rdata
);
	initial begin
		cmd_code = 8'h00;
		cmd_wr = 1'b0;
		cmd_wdata = 16'h0000;
	end
	// one write held across one edge, then stale data scrambled
	task automatic wr(input logic [7:0] c, input logic [15:0] d);
		@(negedge mclk);
		cmd_code = c;
		cmd_wr = 1'b1;
		cmd_wdata = d;
		@(negedge mclk);
		cmd_wr = 1'b0;
		cmd_wdata = ~d;
	endtask
	// read data taken at the next rising edge
	task automatic rd(input logic [7:0] c, output logic [15:0] d);
		@(negedge mclk);
		cmd_code = c;
		@(posedge mclk);
		d = cmd_rdata;
	endtask
endmodule

// [ocft_fault_response_assertions.sv]
// port assertions for the fault response block
// bound into every instance, sees its ports only
`timescale 1ns/1ps
module ocft_fault_response_assertions(
	// watched ports
	input wire logic mclk,
	input wire logic nrst,
	input wire logic cmd_hit,
	input wire logic [15:0] cmd_rdata,
	input wire logic [15:0] iout_meas,
	input wire logic other_fault,
	input wire logic fault_clear,
	input wire logic ctrl_pin,
	input wire logic out_enable,
	input wire logic [15:0] current_limit_value,
	input wire logic oc_fault_flag,
	input wire logic oc_warn_flag,
	input wire logic ot_fault_flag,
	input wire logic host_alert
);
	default clocking @(posedge mclk); endclocking
	default disable iff (!nrst);
	alert_or_a: assert property (host_alert == (oc_fault_flag | oc_warn_flag | ot_fault_flag))
		else $error("alert mismatch");
	oc_hold_a: assert property (oc_fault_flag && !fault_clear |=> oc_fault_flag)
		else $error("oc flag dropped");
	warn_hold_a: assert property (oc_warn_flag && !fault_clear |=> oc_warn_flag)
		else $error("warn flag dropped");
	ot_hold_a: assert property (ot_fault_flag && !fault_clear |=> ot_fault_flag)
		else $error("ot flag dropped");
	oc_cause_a: assert property ($rose(oc_fault_flag) |-> $past(iout_meas) > current_limit_value)
		else $error("oc flag without cause");
	other_off_a: assert property (other_fault [*5] |-> !out_enable)
		else $error("on during other fault");
	ctrl_off_a: assert property (!ctrl_pin [*5] |-> !out_enable)
		else $error("on while commanded off");
	unknown_zero_a: assert property (!cmd_hit |-> cmd_rdata == 16'h0000)
		else $error("unmapped read not zero");
endmodule
bind ocft_fault_response ocft_fault_response_assertions i_chk(.*);

// [ocft_fault_response_tb.sv]
// self-checking bench for the fault response block
// inputs change on falling edges, registers go through the host model
`timescale 1ns/1ps
module ocft_fault_response_tb;
	import ocft_pkg::*;
	localparam int U = 10;
	logic mclk, nrst, cmd_wr, cmd_hit, restart_ok, other_fault, fault_clear, ctrl_pin, bias_good;
	logic out_enable, current_limit, oc_fault_flag, oc_warn_flag, ot_fault_flag, host_alert;
	logic [7:0] cmd_code;
	logic [15:0] cmd_wdata, cmd_rdata, iout_meas, temp_meas, current_limit_value, rd;
	logic [2:0] retries_left;
	int mismatches = 0;
	int checks = 0;
	ocft_fault_response #(.UNIT_CLKS(U)) i_dut(.*);
	ocft_host_model i_host(.mclk(mclk), .cmd_code(cmd_code), .cmd_wr(cmd_wr), .cmd_wdata(cmd_wdata),
		.cmd_rdata(cmd_rdata));
	// clock
	initial begin
		mclk = 1'b0;
		forever #5 mclk = ~mclk;
	end
	task automatic cmp(input string n, input logic [15:0] e, input logic [15:0] s);
		checks++;
		if (s !== e) begin
			mismatches++;
			$display("unexpected %s expected %h seen %h", n, e, s);
		end
	endtask
	task automatic conclude;
		$display("checks %0d mismatches %0d", checks, mismatches);
		if (mismatches == 0 && checks > 0) $display("STATUS OK");
		else $display("STATUS NOT OK");
		$finish;
	endtask
	// drop the fault cause, clear, wait for the output to return
	task automatic release_fault;
		iout_meas = 16'h0000;
		temp_meas = 16'h0000;
		restart_ok = 1'b1;
		@(negedge mclk);
		fault_clear = 1'b1;
		@(negedge mclk);
		fault_clear = 1'b0;
		for (int i = 0; i < 30 && out_enable !== 1'b1; i++) @(negedge mclk);
		restart_ok = 1'b0;
		@(negedge mclk);
	endtask
	task automatic t_regs;
		i_host.rd(CMD_OC_REACTION, rd);
		cmp("reaction reset", 16'h00c0, rd);
		i_host.wr(CMD_OC_WARN_THR, 16'hf064);
		i_host.rd(CMD_OC_WARN_THR, rd);
		cmp("warn thr", 16'hf064, rd);
		cmp("hit", 1, cmd_hit);
		i_host.rd(8'h48, rd);
		cmp("unmapped", 16'h0000, rd);
		cmp("no hit", 0, cmd_hit);
		$display("regs done");
	endtask
	task automatic t_flags;
		i_host.wr(CMD_OC_FAULT_THR, 16'hf0c8);
		i_host.wr(CMD_OT_FAULT_THR, 16'h0055);
		iout_meas = 16'hf064;
		temp_meas = 16'h0055;
		repeat (3) @(negedge mclk);
		cmp("warn at equal", 0, oc_warn_flag);
		cmp("ot at equal", 0, ot_fault_flag);
		iout_meas = 16'hf065;
		temp_meas = 16'h0056;
		repeat (2) @(negedge mclk);
		cmp("warn above", 1, oc_warn_flag);
		cmp("ot above", 1, ot_fault_flag);
		cmp("alert", 1, host_alert);
		release_fault;
		cmp("cleared", 0, host_alert);
		$display("flags done");
	endtask
	task automatic t_limit;
		i_host.wr(CMD_OC_REACTION, 16'h0000);
		iout_meas = 16'hf0c9;
		repeat (3) @(negedge mclk);
		cmp("limiting", 1, current_limit);
		cmp("still on", 1, out_enable);
		cmp("oc flag", 1, oc_fault_flag);
		cmp("limit value", 16'hf0c8, current_limit_value);
		release_fault;
		$display("limit done");
	endtask
	task automatic t_retry;
		int rises, f, r;
		logic prev;
		for (int n = 0; n < 8; n++) begin
			i_host.wr(CMD_OC_REACTION, {8'h00, RESP_DISABLE, 3'(n), 3'h1});
			iout_meas = 16'hf0c9;
			rises = 0;
			f = 0;
			r = 0;
			prev = out_enable;
			for (int t = 1; t < 200; t++) begin
				@(negedge mclk);
				if (prev && !out_enable && f == 0) f = t;
				if (!prev && out_enable) begin
					rises++;
					if (r == 0) r = t;
				end
				prev = out_enable;
			end
			cmp("restarts", (n == 7) ? 9 : n, (rises > 9) ? 9 : rises);
			cmp("interval", 1, n == 0 || (r - f >= U && r - f <= U + 3));
			release_fault;
			cmp("reloaded", n, retries_left);
		end
		$display("retry done");
	endtask
	task automatic t_off;
		other_fault = 1'b1;
		repeat (8) @(negedge mclk);
		cmp("other fault off", 0, out_enable);
		other_fault = 1'b0;
		ctrl_pin = 1'b0;
		repeat (8) @(negedge mclk);
		cmp("ctrl off", 0, out_enable);
		ctrl_pin = 1'b1;
		repeat (8) @(negedge mclk);
		cmp("back on", 1, out_enable);
		$display("off done");
	endtask
	// watchdog
	initial begin
		#100000;
		mismatches++;
		conclude;
	end
	// reset, then the scenarios
	initial begin
		nrst = 1'b0;
		{restart_ok, other_fault, fault_clear} = 3'h0;
		{ctrl_pin, bias_good} = 2'h3;
		iout_meas = 16'h0000;
		temp_meas = 16'h0000;
		repeat (4) @(negedge mclk);
		nrst = 1'b1;
		repeat (5) @(negedge mclk);
		t_regs;
		t_flags;
		t_limit;
		t_retry;
		t_off;
		conclude;
	end
endmodule
